// File: rtl/mil_cfg.svh
`ifndef MIL_CFG_SVH
`define MIL_CFG_SVH
`define MIL_ADR_CTRL 4'h0
`define MIL_ADR_PFLAG 4'h1
`define MIL_ADR_PEN 4'h2
`define MIL_ADR_OPT 4'h3
`define MIL_ADR_CORE 4'h4
`define MIL_ADR_STAT 4'h5
`define MIL_B_GIE 7
`define MIL_B_PERIPHERAL_IRQ_GATE 6
`define MIL_B_TIE 5
`define MIL_B_XIE 4
`define MIL_B_PIE 3
`define MIL_B_TIF 2
`define MIL_B_XIF 1
`define MIL_B_PIF 0
`define MIL_B_EDGE 6
`define MIL_B_SLEEP 0
`define MIL_B_RETI 1
`define MIL_CTRL_RST 8'h00
`define MIL_OPT_RST 8'hFF
`define MIL_VECTOR 13'h0004
`define MIL_LAT_MIN 3
`define MIL_LAT_MAX 4
`endif

// File: rtl/mil_pkg.sv
package mil_pkg;
	typedef struct packed {
		logic [31:0] dat;
		logic [3:0] sel;
		logic [3:0] adr;
		logic we;
		logic stb;
		logic cyc;
	} mil_wb_req_t;
	typedef struct packed {
		logic take;
		logic [12:0] vector;
		logic wake;
	} mil_core_req_t;
	typedef enum logic [1:0] {
		MIL_RUN = 2'b00,
		MIL_WAIT = 2'b01,
		MIL_SLEEP = 2'b10
	} mil_state_t;
endpackage

// File: rtl/mil_sync.sv
`timescale 1ns/1ps
module mil_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] s1_r;
	// Second stage alone reads the first
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s1_r <= '0;
			o_q <= '0;
		end else begin
			s1_r <= i_d;
			o_q <= s1_r;
		end
	end
endmodule

// File: rtl/mil_wb_slave.sv
`timescale 1ns/1ps
module mil_wb_slave
	import mil_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire mil_wb_req_t i_req,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic o_ack,
	output logic [31:0] o_dat
);
	wire req_new = i_req.cyc && i_req.stb && !o_ack;
	// Ack one cycle after request, so write lands once
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
			o_wr <= 1'b0;
			o_dat <= 32'h0000_0000;
		end else begin
			o_ack <= req_new;
			o_wr <= req_new && i_req.we && i_req.sel[0];
			o_dat <= {24'h00_0000, i_rdata};
		end
	end
endmodule

// File: rtl/mil_irq.sv
`timescale 1ns/1ps
`include "mil_cfg.svh"
// Summary of operation
// - Flags set on their event regardless of any enable
// - Control bit 7 is global enable; clear blocks all interrupts
// - Global enable plus flagged enabled source vectors on third instruction cycle of wait
// - Reset clears the global enable
// - Return-from-interrupt sets global enable again
// - Service clears global enable, pushes return, vectors to 0004h
// - Peripheral flags and enables in own registers, group gate
// - External event latency three or four instruction cycles
// - Pin edge chosen by option bit 6; sets control bit 1
// - Pin interrupt masked by control bit 4
// - Pin interrupt wakes sleep if enabled; global enable picks path
// - Timer FFh to 00h sets bit 2; enable is bit 5
// - Upper port pin change sets bit 0; enable is bit 3
// - Hardware saves only return address
// - Wake with global enable set loads vector 0004h
// - Up to nine sources, each with own flag
// - Enabled interrupt wakes regardless of global enable
module mil_irq
	import mil_pkg::*;
#(
	parameter int PERIPH_N = 6
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Wishbone slave
	input wire mil_wb_req_t i_wb,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	// Sources
	input wire logic i_ext_irq_pin,
	input wire logic [3:0] i_upper_port_pins,
	input wire logic i_timer_zero_wrap,
	input wire logic [PERIPH_N-1:0] i_periph_evt,
	// Core sequencer
	input wire logic i_instr_cycle,
	input wire logic i_return_from_irq_instr,
	input wire logic i_sleep_instr,
	output mil_core_req_t o_core,
	output logic o_push_ret,
	output logic o_sleeping
);
	// Three core flags plus up to six peripheral flags make nine sources
	if (PERIPH_N < 1 || PERIPH_N > 6) begin
		$error("PERIPH_N must be 1..6");
	end

	logic [7:0] ctrl_r;
	logic [7:0] pflag_r;
	logic [7:0] pen_r;
	logic [7:0] opt_r;
	mil_state_t st_r;
	mil_state_t st_nxt;
	logic [2:0] lat_r;
	logic [1:0] core_r;
	logic pin_d_r;
	logic [3:0] port_d_r;
	logic wr;
	logic [7:0] rdata;
	logic pin_s;
	logic [3:0] port_s;
	logic [7:0] ctrl_nxt;
	logic [7:0] pflag_nxt;
	logic [7:0] pen_nxt;
	logic [7:0] opt_nxt;
	logic [2:0] lat_nxt;
	logic [1:0] prime_r;
	logic [1:0] prime_nxt;
	logic src_ready;
	logic gie_nxt;
	logic wake_nxt;
	logic sleep_nxt;
	logic [1:0] core_nxt;
	logic [7:0] rd_stat;

	mil_sync #(.W(1)) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_d(i_ext_irq_pin),
		.o_q(pin_s)
	);
	mil_sync #(.W(4)) u_port_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_d(i_upper_port_pins),
		.o_q(port_s)
	);
	mil_wb_slave u_wb (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_req(i_wb),
		.i_rdata(rdata),
		.o_wr(wr),
		.o_ack(o_wb_ack),
		.o_dat(o_wb_dat)
	);

	function automatic logic [7:0] set_wins(input logic [7:0] cur,
		input logic [7:0] wdat, input logic we, input logic [7:0] setv);
		set_wins = (we ? wdat : cur) | setv;
	endfunction

	function automatic logic adr_hit(input logic [3:0] adr,
		input logic [3:0] code);
		adr_hit = adr == code;
	endfunction

	// Register select, shared by the write strobes and the read mux
	wire sel_ctrl = adr_hit(i_wb.adr, `MIL_ADR_CTRL);
	wire sel_pflag = adr_hit(i_wb.adr, `MIL_ADR_PFLAG);
	wire sel_pen = adr_hit(i_wb.adr, `MIL_ADR_PEN);
	wire sel_opt = adr_hit(i_wb.adr, `MIL_ADR_OPT);
	wire sel_stat = adr_hit(i_wb.adr, `MIL_ADR_STAT);

	// Write strobe comes one cycle after the request; address held
	wire [7:0] wdat = i_wb.dat[7:0];
	wire wr_ctrl = wr && sel_ctrl;
	wire wr_pflag = wr && sel_pflag;
	wire wr_pen = wr && sel_pen;
	wire wr_opt = wr && sel_opt;

	// Sync stages and history hold reset values for three edges;
	// a real edge that early is lost, but no false flag follows reset
	assign src_ready = prime_r == 2'h3;
	assign prime_nxt = src_ready ? prime_r : prime_r + 2'h1;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			prime_r <= 2'h0;
		end else begin
			prime_r <= prime_nxt;
		end
	end

	wire pin_rise = pin_s && !pin_d_r;
	wire pin_fall = !pin_s && pin_d_r;
	wire pin_edge = opt_r[`MIL_B_EDGE] ? pin_rise : pin_fall;
	wire pin_evt = src_ready && pin_edge;
	wire port_evt = src_ready && |(port_s ^ port_d_r);
	wire tmr_evt = i_timer_zero_wrap;

	wire [7:0] core_set = {5'h00, tmr_evt, pin_evt, port_evt};
	wire [7:0] per_set = {{(8-PERIPH_N){1'b0}}, i_periph_evt};
	wire [7:0] per_mask = {{(8-PERIPH_N){1'b0}}, {PERIPH_N{1'b1}}};

	wire pin_hit = ctrl_r[`MIL_B_XIF] & ctrl_r[`MIL_B_XIE];
	wire tmr_hit = ctrl_r[`MIL_B_TIF] & ctrl_r[`MIL_B_TIE];
	wire port_hit = ctrl_r[`MIL_B_PIF] & ctrl_r[`MIL_B_PIE];
	wire core_hit = tmr_hit | pin_hit | port_hit;
	wire per_hit = ctrl_r[`MIL_B_PERIPHERAL_IRQ_GATE] & |(pflag_r & pen_r);
	wire pending = core_hit | per_hit;
	wire irq_req = pending & ctrl_r[`MIL_B_GIE];

	wire lat_done = lat_r >= 3'(`MIL_LAT_MIN - 1) && i_instr_cycle;
	wire take = st_r == MIL_WAIT && lat_done && ctrl_r[`MIL_B_GIE];

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			MIL_RUN: begin
				if (i_sleep_instr && !pending) begin
					st_nxt = MIL_SLEEP;
				end else if (irq_req) begin
					st_nxt = MIL_WAIT;
				end
			end
			MIL_WAIT: begin
				if (!ctrl_r[`MIL_B_GIE] || take) begin
					st_nxt = MIL_RUN;
				end
			end
			MIL_SLEEP: begin
				if (pending) begin
					st_nxt = ctrl_r[`MIL_B_GIE] ? MIL_WAIT : MIL_RUN;
				end
			end
			default: st_nxt = MIL_RUN;
		endcase
	end

	// Set wins over a software clear in the same cycle
	wire [7:0] ctrl_set = set_wins(ctrl_r, wdat, wr_ctrl, core_set);
	assign gie_nxt = take ? 1'b0
		: i_return_from_irq_instr ? 1'b1
		: ctrl_set[`MIL_B_GIE];
	assign ctrl_nxt = {gie_nxt, ctrl_set[6:0]};

	// peripheral flags masked to the fitted sources
	assign pflag_nxt = set_wins(pflag_r, wdat, wr_pflag, per_set)
		& per_mask;
	assign pen_nxt = (wr_pen ? wdat : pen_r) & per_mask;
	assign opt_nxt = wr_opt ? wdat : opt_r;

	// instruction cycles counted while waiting; saturates
	assign lat_nxt = st_r != MIL_WAIT ? 3'h0
		: i_instr_cycle && lat_r < 3'(`MIL_LAT_MAX) ? lat_r + 3'h1
		: lat_r;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_r <= `MIL_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			pflag_r <= 8'h00;
		end else begin
			pflag_r <= pflag_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			pen_r <= 8'h00;
		end else begin
			pen_r <= pen_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			opt_r <= `MIL_OPT_RST;
		end else begin
			opt_r <= opt_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			st_r <= MIL_RUN;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			lat_r <= 3'h0;
		end else begin
			lat_r <= lat_nxt;
		end
	end

	// Edge history, one stage behind the synchronisers
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			pin_d_r <= 1'b0;
		end else begin
			pin_d_r <= pin_s;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			port_d_r <= 4'h0;
		end else begin
			port_d_r <= port_s;
		end
	end

	assign wake_nxt = st_r == MIL_SLEEP && st_nxt != MIL_SLEEP;
	assign sleep_nxt = st_nxt == MIL_SLEEP;
	assign core_nxt = {take, pending};

	// vector 0004h loaded every cycle out of reset
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_core <= '0;
		end else begin
			o_core.take <= take;
			o_core.vector <= `MIL_VECTOR;
			o_core.wake <= wake_nxt;
		end
	end

	// only the return address is pushed
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_push_ret <= 1'b0;
		end else begin
			o_push_ret <= take;
		end
	end

	// sleep state shown to the core
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_sleeping <= 1'b0;
		end else begin
			o_sleeping <= sleep_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			core_r <= 2'h0;
		end else begin
			core_r <= core_nxt;
		end
	end

	// software clears flags; reads show live flags
	// up to nine flags: three core, up to six peripheral
	assign rd_stat = {5'h00, st_r == MIL_SLEEP, core_r};
	// Status is read-only; a write to it is dropped
	assign rdata = sel_ctrl ? ctrl_r
		: sel_pflag ? pflag_r
		: sel_pen ? pen_r
		: sel_opt ? opt_r
		: sel_stat ? rd_stat
		: 8'h00;
endmodule

// File: tb/mil_irq_checker.sv
`timescale 1ns/1ps
module mil_irq_checker
	import mil_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_instr_cycle,
	input wire mil_core_req_t o_core,
	input wire logic o_push_ret,
	input wire logic o_sleeping
);
	logic [2:0] pc_r;
	// Saturates so a long idle spell cannot wrap
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || o_core.take) begin
			pc_r <= 3'h0;
		end else if (i_instr_cycle && pc_r != 3'h7) begin
			pc_r <= pc_r + 3'h1;
		end
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence quiet_s;
		!o_core.take [*3];
	endsequence
	vec_addr_a: assert property (o_core.take |-> o_core.vector == 13'h0004)
		else $error("bad vector");
	take_gap_a: assert property (o_core.take |=> quiet_s)
		else $error("take repeated");
	push_pair_a: assert property (o_push_ret == o_core.take)
		else $error("push without take");
	take_pace_a: assert property (o_core.take |-> $past(i_instr_cycle))
		else $error("take off cycle");
	lat_min_a: assert property (o_core.take |-> pc_r >= 3'h3)
		else $error("take too early");
	rst_quiet_a: assert property ($rose(i_rst_n) |-> !o_core.take ##1 !o_core.take)
		else $error("take after reset");
	wake_src_a: assert property (o_core.wake |-> $past(o_sleeping))
		else $error("wake while awake");
	take_awake_a: assert property (o_core.take |-> !o_sleeping)
		else $error("take in sleep");
endmodule
bind mil_irq mil_irq_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_instr_cycle(i_instr_cycle), .o_core(o_core), .o_push_ret(o_push_ret),
	.o_sleeping(o_sleeping));

// File: tb/mil_core_model.sv
`timescale 1ns/1ps
module mil_core_model
	import mil_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_slow,
	input wire mil_core_req_t i_core,
	output logic o_instr_cycle,
	output int o_takes,
	output int o_wakes
);
	logic [3:0] div_r;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			div_r <= 4'h0;
			o_takes <= 0;
			o_wakes <= 0;
		end else begin
			div_r <= (div_r >= (i_slow ? 4'h8 : 4'h3)) ? 4'h0 : div_r + 4'h1;
			o_takes <= o_takes + int'(i_core.take);
			o_wakes <= o_wakes + int'(i_core.wake);
		end
	end
	assign o_instr_cycle = i_rst_n && div_r == 4'h0;
endmodule

// File: tb/mil_irq_bench.sv
`timescale 1ns/1ps
module mil_irq_bench
	import mil_pkg::*;
;
	logic clk, rst_n, ack, pin, tw, ret, slp, ic, push, slpg, slow;
	logic [3:0] pins;
	logic [5:0] pev;
	logic [31:0] dat;
	mil_wb_req_t wb;
	mil_core_req_t core;
	int takes;
	int wakes;
	int mismatches = 0;
	int total_checks = 0;
	mil_irq #(.PERIPH_N(6)) u_mil_irq (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_wb(wb), .o_wb_ack(ack), .o_wb_dat(dat), .i_ext_irq_pin(pin),
		.i_upper_port_pins(pins), .i_timer_zero_wrap(tw), .i_periph_evt(pev),
		.i_instr_cycle(ic), .i_return_from_irq_instr(ret),
		.i_sleep_instr(slp), .o_core(core), .o_push_ret(push),
		.o_sleeping(slpg));
	mil_core_model u_mil_core_model (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_slow(slow), .i_core(core), .o_instr_cycle(ic), .o_takes(takes),
		.o_wakes(wakes));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(logic [3:0] a, logic w, logic [7:0] d, output logic [31:0] q);
		int n;
		wb <= '{dat: {24'h0, d}, sel: 4'hF, adr: a, we: w, stb: 1'h1, cyc: 1'h1};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 50);
		q = dat;
		if (ack !== 1'h1) begin
			mismatches++;
			wrap_up();
		end
		wb <= '0;
		@(posedge clk);
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		logic [31:0] q;
		bus(a, 1'h1, d, q);
	endtask
	task automatic rd(logic [3:0] a, logic [7:0] e);
		logic [31:0] q;
		bus(a, 1'h0, 8'h00, q);
		chk($sformatf("reg%0d", a), {24'h0, e}, q);
	endtask
	task automatic waitt(int t);
		int n;
		n = 0;
		while (takes != t && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("takes", t, takes);
		if (takes != t) begin
			wrap_up();
		end
	endtask
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst_n = 1'h0; wb = '0; pin = 1'h1; pins = 4'h0; tw = 1'h0;
		pev = 6'h00; ret = 1'h0; slp = 1'h0; slow = 1'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		rd(4'h0, 8'h00);
		rd(4'h3, 8'hFF);
		rd(4'h4, 8'h00);
		$display("reset test done");
		wr(4'h3, 8'hBF);
		pin <= 1'h0; pins <= 4'hA; tw <= 1'h1; pev <= 6'h01;
		@(posedge clk);
		tw <= 1'h0; pev <= 6'h00;
		repeat (6) @(posedge clk);
		rd(4'h0, 8'h07);
		rd(4'h1, 8'h01);
		chk("takes", 0, takes);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h00);
		pin <= 1'h1;
		repeat (6) @(posedge clk);
		rd(4'h0, 8'h00);
		$display("flag test done");
		wr(4'h0, 8'hA0);
		tw <= 1'h1;
		@(posedge clk);
		tw <= 1'h0;
		waitt(1);
		rd(4'h0, 8'h24);
		wr(4'h0, 8'h20);
		ret <= 1'h1;
		@(posedge clk);
		ret <= 1'h0;
		@(posedge clk);
		rd(4'h0, 8'hA0);
		$display("vector test done");
		slow <= 1'h1;
		wr(4'h2, 8'h01);
		wr(4'h0, 8'hC0);
		pin <= 1'h0;
		repeat (8) @(posedge clk);
		chk("takes", 1, takes);
		pev <= 6'h01;
		@(posedge clk);
		pev <= 6'h00;
		waitt(2);
		rd(4'h0, 8'h42);
		wr(4'h1, 8'h00);
		$display("group test done");
		wr(4'h0, 8'h10);
		slp <= 1'h1;
		@(posedge clk);
		slp <= 1'h0;
		@(posedge clk);
		chk("sleep", 1, slpg);
		pin <= 1'h1;
		repeat (4) @(posedge clk);
		pin <= 1'h0;
		repeat (8) @(posedge clk);
		chk("sleep", 0, slpg);
		chk("takes", 2, takes);
		chk("wakes", 1, wakes);
		$display("sleep test done");
		wr(4'h3, 8'hFF);
		wr(4'h0, 8'h90);
		slp <= 1'h1;
		@(posedge clk);
		slp <= 1'h0;
		@(posedge clk);
		chk("sleep", 1, slpg);
		pin <= 1'h1;
		waitt(3);
		chk("wakes", 2, wakes);
		rd(4'h0, 8'h12);
		rd(4'h5, 8'h01);
		$display("wake vector test done");
		wrap_up();
	end
endmodule
